/* design/scan_port.sv */
`timescale 1ns/1ps
module scan_port
  import scan_port_pkg::*;
(
  // Core clock and reset
  input  wire logic                 MCLK,
  input  wire logic                 NRST,
  // Test access pins
  input  wire logic                 TCK,
  input  wire logic                 TMS,
  input  wire logic                 TDI,
  output logic                      TDO,
  output logic                      TDO_OE,
  // Pin side of the boundary cells
  input  wire logic [CHAIN_LEN-1:0] CORE_OUT,
  input  wire logic [CHAIN_LEN-1:0] PIN_IN,
  output logic      [CHAIN_LEN-1:0] PIN_OUT
);

  // TCK-domain reset synchroniser
  logic                 trst_meta_r;  // First stage, read only by second
  logic                 trst_n_r;     // Released reset for TCK logic

  // Pin level synchroniser into TCK
  logic [CHAIN_LEN-1:0] pin_meta_r;   // First stage
  logic [CHAIN_LEN-1:0] pin_sync_r;   // Stable pin levels

  // TAP state and registers
  tap_state_t           state_r, state_nxt;
  logic [IR_LEN-1:0]    ir_shift_r, ir_shift_nxt;   // Instruction shifter
  logic [IR_LEN-1:0]    ir_r, ir_nxt;               // Active instruction
  logic [CHAIN_LEN-1:0] chain_r, chain_nxt;         // Boundary cell chain
  logic [ID_LEN-1:0]    id_shift_r, id_shift_nxt;   // Identification shifter
  logic                 pass_r, pass_nxt;           // Single-bit pass register
  logic [CHAIN_LEN-1:0] update_r, update_nxt;       // Parallel update latch
  logic                 extest_r, extest_nxt;       // EXTEST owns the pins
  logic                 tgl_r, tgl_nxt;             // Event toggle to MCLK
  tdo_drive_t           drive_r, drive_nxt;         // Falling-edge output

  // MCLK-domain receive side
  logic                 tgl_meta_r;                 // First stage
  logic                 tgl_sync_r;                 // Synchronised toggle
  logic                 tgl_seen_r, tgl_seen_nxt;   // Last toggle consumed
  logic [CHAIN_LEN-1:0] hold_r, hold_nxt;           // Pattern in MCLK domain
  logic                 ext_hold_r, ext_hold_nxt;   // EXTEST in MCLK domain
  logic [CHAIN_LEN-1:0] out_r, out_nxt;             // Pin drive

  // Fixed identification word
  id_word_t             id_word;
  dr_sel_t              sel;

  assign id_word = '{revision: REVISION_VAL, part: PART_VAL,
                     producer: PRODUCER_VAL, fixed_one: ID_FIXED_BIT};
  assign sel     = decode_sel(ir_r);

  // Reset release is synchronised so TAP flops leave reset on a TCK edge
  always_ff @(posedge TCK or negedge NRST) begin
    if (!NRST) begin
      trst_meta_r <= 1'h0;
      trst_n_r    <= 1'h0;
    end else begin
      trst_meta_r <= 1'h1;
      trst_n_r    <= trst_meta_r;
    end
  end

  // Pins are asynchronous to TCK, so each bit passes two flops
  always_ff @(posedge TCK or negedge trst_n_r) begin
    if (!trst_n_r) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      pin_meta_r <= PIN_IN;
      pin_sync_r <= pin_meta_r;
    end
  end

  // State transitions, TMS sampled on each rising TCK
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RESET:      state_nxt = TMS ? ST_RESET     : ST_IDLE;
      ST_IDLE:       state_nxt = TMS ? ST_SELECT_DR : ST_IDLE;
      ST_SELECT_DR:  state_nxt = TMS ? ST_SELECT_IR : ST_CAPTURE_DR;
      ST_CAPTURE_DR: state_nxt = TMS ? ST_EXIT1_DR  : ST_SHIFT_DR;
      ST_SHIFT_DR:   state_nxt = TMS ? ST_EXIT1_DR  : ST_SHIFT_DR;
      ST_EXIT1_DR:   state_nxt = TMS ? ST_UPDATE_DR : ST_PAUSE_DR;
      ST_PAUSE_DR:   state_nxt = TMS ? ST_EXIT2_DR  : ST_PAUSE_DR;
      ST_EXIT2_DR:   state_nxt = TMS ? ST_UPDATE_DR : ST_SHIFT_DR;
      ST_UPDATE_DR:  state_nxt = TMS ? ST_SELECT_DR : ST_IDLE;
      ST_SELECT_IR:  state_nxt = TMS ? ST_RESET     : ST_CAPTURE_IR;
      ST_CAPTURE_IR: state_nxt = TMS ? ST_EXIT1_IR  : ST_SHIFT_IR;
      ST_SHIFT_IR:   state_nxt = TMS ? ST_EXIT1_IR  : ST_SHIFT_IR;
      ST_EXIT1_IR:   state_nxt = TMS ? ST_UPDATE_IR : ST_PAUSE_IR;
      ST_PAUSE_IR:   state_nxt = TMS ? ST_EXIT2_IR  : ST_PAUSE_IR;
      ST_EXIT2_IR:   state_nxt = TMS ? ST_UPDATE_IR : ST_SHIFT_IR;
      ST_UPDATE_IR:  state_nxt = TMS ? ST_SELECT_DR : ST_IDLE;
    endcase
  end

  // Instruction path
  always_comb begin
    ir_shift_nxt = ir_shift_r;
    ir_nxt       = ir_r;
    extest_nxt   = extest_r;
    unique case (state_r)
      ST_RESET: begin
        // Test-Logic-Reset reloads IDCODE and clears extest_r; the pins stay held until the next update toggle
        ir_nxt     = IR_RESET_VAL;
        extest_nxt = 1'h0;
      end
      ST_CAPTURE_IR: ir_shift_nxt = IR_CAPTURE_VAL;
      ST_SHIFT_IR:   ir_shift_nxt = {TDI, ir_shift_r[IR_LEN-1:1]};
      ST_UPDATE_IR: begin
        ir_nxt     = ir_shift_r;
        extest_nxt = (ir_shift_r == OP_EXTEST);
      end
      default: ;
    endcase
  end

  // Data register capture and shift
  always_comb begin
    chain_nxt    = chain_r;
    id_shift_nxt = id_shift_r;
    pass_nxt     = pass_r;
    update_nxt   = update_r;
    tgl_nxt      = tgl_r;
    if (state_r == ST_CAPTURE_DR) begin
      unique case (sel)
        SEL_CHAIN: chain_nxt    = pin_sync_r;
        SEL_ID:    id_shift_nxt = id_word;
        SEL_PASS:  pass_nxt     = PASS_CAPTURE_VAL;
      endcase
    end else if (state_r == ST_SHIFT_DR) begin
      unique case (sel)
        SEL_CHAIN: chain_nxt    = {TDI, chain_r[CHAIN_LEN-1:1]};
        SEL_ID:    id_shift_nxt = {TDI, id_shift_r[ID_LEN-1:1]};
        SEL_PASS:  pass_nxt     = TDI;
      endcase
    end else if (state_r == ST_UPDATE_DR && sel == SEL_CHAIN) begin
      // Preload or EXTEST pattern moves to the parallel latch
      update_nxt = chain_r;
    end
    // Any update, DR or IR, tells the core domain to resample
    if (state_r == ST_UPDATE_DR || state_r == ST_UPDATE_IR) begin
      tgl_nxt = ~tgl_r;
    end
  end

  // Serial output, changed on the falling edge for a half-period of setup
  always_comb begin
    drive_nxt = '{data: 1'h0, enable: 1'h0};
    if (state_r == ST_SHIFT_IR) begin
      drive_nxt = '{data: ir_shift_r[0], enable: 1'h1};
    end else if (state_r == ST_SHIFT_DR) begin
      unique case (sel)
        SEL_CHAIN: drive_nxt = '{data: chain_r[0],    enable: 1'h1};
        SEL_ID:    drive_nxt = '{data: id_shift_r[0], enable: 1'h1};
        SEL_PASS:  drive_nxt = '{data: pass_r,        enable: 1'h1};
      endcase
    end
  end

  // TCK rising-edge registers
  always_ff @(posedge TCK or negedge trst_n_r) begin
    if (!trst_n_r) begin
      state_r    <= ST_RESET;
      ir_shift_r <= IR_RESET_VAL;
      ir_r       <= IR_RESET_VAL;
      chain_r    <= '0;
      id_shift_r <= '0;
      pass_r     <= PASS_CAPTURE_VAL;
      update_r   <= '0;
      extest_r   <= 1'h0;
      tgl_r      <= 1'h0;
    end else begin
      state_r    <= state_nxt;
      ir_shift_r <= ir_shift_nxt;
      ir_r       <= ir_nxt;
      chain_r    <= chain_nxt;
      id_shift_r <= id_shift_nxt;
      pass_r     <= pass_nxt;
      update_r   <= update_nxt;
      extest_r   <= extest_nxt;
      tgl_r      <= tgl_nxt;
    end
  end

  // TCK falling-edge output register
  always_ff @(negedge TCK or negedge trst_n_r) begin
    if (!trst_n_r) begin
      drive_r <= '{data: 1'h0, enable: 1'h0};
    end else begin
      drive_r <= drive_nxt;
    end
  end

  // Toggle crossing into MCLK; first flop feeds only the second
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      tgl_meta_r <= 1'h0;
      tgl_sync_r <= 1'h0;
    end else begin
      tgl_meta_r <= tgl_r;
      tgl_sync_r <= tgl_meta_r;
    end
  end

  // Words are taken only after the toggle arrives, when they are long settled
  always_comb begin
    tgl_seen_nxt = tgl_sync_r;
    hold_nxt     = hold_r;
    ext_hold_nxt = ext_hold_r;
    if (tgl_sync_r != tgl_seen_r) begin
      hold_nxt     = update_r;
      ext_hold_nxt = extest_r;
    end
    // Normal core path unless EXTEST owns the pins
    out_nxt = ext_hold_r ? hold_r : CORE_OUT;
  end

  // MCLK registers
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      tgl_seen_r <= 1'h0;
      hold_r     <= '0;
      ext_hold_r <= 1'h0;
      out_r      <= '0;
    end else begin
      tgl_seen_r <= tgl_seen_nxt;
      hold_r     <= hold_nxt;
      ext_hold_r <= ext_hold_nxt;
      out_r      <= out_nxt;
    end
  end

  // Outputs straight from flops
  assign TDO     = drive_r.data;
  assign TDO_OE  = drive_r.enable;
  assign PIN_OUT = out_r;

endmodule : scan_port

/* design/scan_port_pkg.sv */
// Behaviour
// - Controlled only by TMS/TCK; TDI/TDO timed by TCK; here NRST also resets the TAP asynchronously
// - Three-bit instruction register, shifted LSB first
// - EXTEST: chain captures pins, shifts out
// - EXTEST: shifted pattern drives pins at Update-DR; here the pins follow a few MCLK cycles later, after the toggle synchroniser
// - SAMPLE/PRELOAD: chain selected, normal pin path kept
// - SAMPLE/PRELOAD: capture all pins in Capture-DR
// - IDCODE: identification register selected and shifted
// - BYPASS: TDI to TDO, one TCK delay
// - Bypass path is a single-bit register
// - Identification register 32 bits, LSB first
// - ID layout: one, producer, part, revision
// - 98-bit chain, used only by EXTEST/SAMPLE
// - Chain applies and reads every pin in parallel
// - Sixteen-state synchronous TAP controller
// - TMS sampled on every rising TCK edge
package scan_port_pkg;

  // Register lengths
  localparam int CHAIN_LEN = 98;
  localparam int IR_LEN    = 3;
  localparam int ID_LEN    = 32;

  // Instruction codes
  localparam logic [2:0] OP_EXTEST = 3'h0;
  localparam logic [2:0] OP_SAMPLE = 3'h4;
  localparam logic [2:0] OP_IDCODE = 3'h6;
  localparam logic [2:0] OP_BYPASS = 3'h7;

  // Instruction register reset and capture values
  localparam logic [2:0] IR_RESET_VAL   = OP_IDCODE;
  localparam logic [2:0] IR_CAPTURE_VAL = 3'h1;

  // Identification fields; the three values are arbitrary
  localparam logic        ID_FIXED_BIT = 1'h1;
  localparam logic [10:0] PRODUCER_VAL = 11'h2A5;
  localparam logic [15:0] PART_VAL     = 16'h5A3C;
  localparam logic [3:0]  REVISION_VAL = 4'h1;

  // Bypass capture value
  localparam logic PASS_CAPTURE_VAL = 1'h0;

  // Identification word, bit 31 first
  typedef struct packed {
    logic [3:0]  revision;
    logic [15:0] part;
    logic [10:0] producer;
    logic        fixed_one;
  } id_word_t;

  // Serial output carrier
  typedef struct packed {
    logic data;
    logic enable;
  } tdo_drive_t;

  // TAP controller states
  typedef enum logic [3:0] {
    ST_EXIT2_DR   = 4'h0,
    ST_EXIT1_DR   = 4'h1,
    ST_SHIFT_DR   = 4'h2,
    ST_PAUSE_DR   = 4'h3,
    ST_SELECT_IR  = 4'h4,
    ST_UPDATE_DR  = 4'h5,
    ST_CAPTURE_DR = 4'h6,
    ST_SELECT_DR  = 4'h7,
    ST_EXIT2_IR   = 4'h8,
    ST_EXIT1_IR   = 4'h9,
    ST_SHIFT_IR   = 4'hA,
    ST_PAUSE_IR   = 4'hB,
    ST_IDLE       = 4'hC,
    ST_UPDATE_IR  = 4'hD,
    ST_CAPTURE_IR = 4'hE,
    ST_RESET      = 4'hF
  } tap_state_t;

  // Data register selection
  typedef enum logic [1:0] {
    SEL_CHAIN = 2'h0,
    SEL_ID    = 2'h1,
    SEL_PASS  = 2'h2
  } dr_sel_t;

  // Instruction decode, shared by capture, shift and output paths
  function automatic dr_sel_t decode_sel(input logic [2:0] op);
    dr_sel_t sel;
    sel = SEL_PASS;
    unique case (op)
      OP_EXTEST: sel = SEL_CHAIN;
      OP_SAMPLE: sel = SEL_CHAIN;
      OP_IDCODE: sel = SEL_ID;
      default:   sel = SEL_PASS;
    endcase
    return sel;
  endfunction : decode_sel

endpackage : scan_port_pkg

/* verification/scan_ctl_model.sv */
`timescale 1ns/1ps
module scan_ctl_model (
  // Test access pins
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input wire logic  tdo,
  input wire logic  tdo_oe
);
  logic line; // Pulled up, so a released TDO reads high

  assign line = tdo_oe ? tdo : 1'b1;

  // Clock stands still between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One TCK period; TDO is taken just before the rise that shifts it
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #16;
    q = line;
    tck = 1'b1;
    #16;
    tck = 1'b0;
  endtask : step

  // Five ones reach Test-Logic-Reset from anywhere, then park in Idle
  task automatic tap_reset();
    logic q;
    repeat (5) step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
  endtask : tap_reset

  // Idle to Shift, n bits LSB first, Update, back to Idle
  task automatic scan(input logic ir, input int n, input logic [97:0] din, output logic [97:0] dout);
    logic q;
    dout = '0;
    step(1'b1, ~tdi, q);
    if (ir) step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
    step(1'b0, ~tdi, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
  endtask : scan
endmodule : scan_ctl_model

/* verification/scan_port_properties.sv */
`timescale 1ns/1ps
module scan_port_checker
  import scan_port_pkg::*;
(
  // Clocks and reset
  input wire logic                 MCLK,
  input wire logic                 NRST,
  input wire logic                 TCK,
  // Test access pins
  input wire logic                 TMS,
  input wire logic                 TDI,
  input wire logic                 TDO,
  input wire logic                 TDO_OE,
  // Pin side
  input wire logic [CHAIN_LEN-1:0] CORE_OUT,
  input wire logic [CHAIN_LEN-1:0] PIN_IN,
  input wire logic [CHAIN_LEN-1:0] PIN_OUT
);
  tap_state_t st_r, st_nxt;     // Mirror of the TAP state
  logic [2:0] sh_r, sh_nxt;     // Instruction being shifted
  logic [2:0] ins_r, ins_nxt;   // Active instruction
  logic [2:0] cnt_r, cnt_nxt;   // MCLK cycles since EXTEST was active
  logic       pass;             // Bypass path selected
  logic       cap_dr;           // First shift after Capture-DR

  assign pass = !(ins_r inside {OP_EXTEST, OP_SAMPLE, OP_IDCODE});

  // Next TAP state and instruction, standard diagram
  always_comb begin
    sh_nxt = sh_r;
    ins_nxt = ins_r;
    unique case (st_r)
      ST_RESET:      st_nxt = TMS ? ST_RESET : ST_IDLE;
      ST_IDLE:       st_nxt = TMS ? ST_SELECT_DR : ST_IDLE;
      ST_SELECT_DR:  st_nxt = TMS ? ST_SELECT_IR : ST_CAPTURE_DR;
      ST_CAPTURE_DR: st_nxt = TMS ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR:   st_nxt = TMS ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR:   st_nxt = TMS ? ST_UPDATE_DR : ST_PAUSE_DR;
      ST_PAUSE_DR:   st_nxt = TMS ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR:   st_nxt = TMS ? ST_UPDATE_DR : ST_SHIFT_DR;
      ST_UPDATE_DR:  st_nxt = TMS ? ST_SELECT_DR : ST_IDLE;
      ST_SELECT_IR:  st_nxt = TMS ? ST_RESET : ST_CAPTURE_IR;
      ST_CAPTURE_IR: st_nxt = TMS ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR:   st_nxt = TMS ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR:   st_nxt = TMS ? ST_UPDATE_IR : ST_PAUSE_IR;
      ST_PAUSE_IR:   st_nxt = TMS ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR:   st_nxt = TMS ? ST_UPDATE_IR : ST_SHIFT_IR;
      default:       st_nxt = TMS ? ST_SELECT_DR : ST_IDLE;
    endcase
    if (st_r == ST_CAPTURE_IR) sh_nxt = IR_CAPTURE_VAL;
    if (st_r == ST_SHIFT_IR) sh_nxt = {TDI, sh_r[2:1]};
    if (st_r == ST_UPDATE_IR) ins_nxt = sh_r;
    if (st_r == ST_RESET) ins_nxt = IR_RESET_VAL;
  end

  // TAP mirror registers
  always_ff @(posedge TCK or negedge NRST) begin
    if (!NRST) begin
      st_r <= ST_RESET;
      sh_r <= IR_CAPTURE_VAL;
      ins_r <= IR_RESET_VAL;
    end else begin
      st_r <= st_nxt;
      sh_r <= sh_nxt;
      ins_r <= ins_nxt;
    end
  end

  // Settle counter; reads ins_r across domains, only a coarse guard
  always_comb cnt_nxt = (ins_r == OP_EXTEST) ? 3'h0 : cnt_r + {2'h0, cnt_r != 3'h7};
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) cnt_r <= 3'h0;
    else cnt_r <= cnt_nxt;
  end

  property p_oe_shift;
    @(posedge TCK) disable iff (!NRST) TDO_OE == (st_r inside {ST_SHIFT_DR, ST_SHIFT_IR});
  endproperty
  a_oe_shift: assert property (p_oe_shift) else $error("TDO enable outside shift");
  property p_tdo_idle;
    @(posedge TCK) disable iff (!NRST) !TDO_OE |-> !TDO;
  endproperty
  a_tdo_idle: assert property (p_tdo_idle) else $error("TDO not low while released");
  property p_ir_capture;
    @(posedge TCK) disable iff (!NRST) st_r == ST_SHIFT_IR && $past(st_r) == ST_CAPTURE_IR
      |-> TDO ##1 (st_r != ST_SHIFT_IR || !TDO);
  endproperty
  a_ir_capture: assert property (p_ir_capture) else $error("Instruction capture bits wrong");
  property p_id_first;
    @(posedge TCK) disable iff (!NRST) st_r == ST_SHIFT_DR && $past(st_r) == ST_CAPTURE_DR
      && ins_r == OP_IDCODE |-> TDO;
  endproperty
  a_id_first: assert property (p_id_first) else $error("Identification bit 0 not one");
  property p_pass_capture;
    @(posedge TCK) disable iff (!NRST) st_r == ST_SHIFT_DR && $past(st_r) == ST_CAPTURE_DR && pass |-> !TDO;
  endproperty
  a_pass_capture: assert property (p_pass_capture) else $error("Bypass capture not zero");
  property p_pass_delay;
    @(posedge TCK) disable iff (!NRST) st_r == ST_SHIFT_DR && $past(st_r) == ST_SHIFT_DR && pass
      |-> TDO == $past(TDI);
  endproperty
  a_pass_delay: assert property (p_pass_delay) else $error("Bypass delay wrong");
  property p_chain_first;
    @(posedge TCK) disable iff (!NRST) st_r == ST_SHIFT_DR && $past(st_r) == ST_CAPTURE_DR
      && !pass && ins_r != OP_IDCODE |-> TDO == $past(PIN_IN[0], 3);
  endproperty
  a_chain_first: assert property (p_chain_first) else $error("Chain bit 0 not captured");
  property p_pins_core;
    @(posedge MCLK) disable iff (!NRST) cnt_r == 3'h7 |-> PIN_OUT == $past(CORE_OUT);
  endproperty
  a_pins_core: assert property (p_pins_core) else $error("Pins left the core path");
endmodule : scan_port_checker

bind scan_port scan_port_checker i_chk (.MCLK(MCLK), .NRST(NRST), .TCK(TCK), .TMS(TMS), .TDI(TDI),
  .TDO(TDO), .TDO_OE(TDO_OE), .CORE_OUT(CORE_OUT), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT));

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import scan_port_pkg::*;
  logic                 mclk, nrst, tck, tms, tdi, tdo, tdo_oe;
  logic [CHAIN_LEN-1:0] core_out, pin_in, pin_out, got;
  int                   mismatches, total_checks;

  scan_port i_dut (.MCLK(mclk), .NRST(nrst), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo),
    .TDO_OE(tdo_oe), .CORE_OUT(core_out), .PIN_IN(pin_in), .PIN_OUT(pin_out));
  scan_ctl_model i_ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

  // 25 MHz core clock
  always #20 mclk = ~mclk;

  task automatic chk(input string what, input logic [97:0] seen, input logic [97:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  // Load an instruction; the captured value comes back first
  task automatic load(input logic [2:0] op);
    logic [97:0] d;
    i_ctl.scan(1'b1, 3, {95'h0, op}, d);
    chk("ir_capture", d, 98'h1);
  endtask : load

  task automatic t_idcode();
    i_ctl.scan(1'b0, 32, '0, got);
    chk("idcode", got, {66'h0, REVISION_VAL, PART_VAL, PRODUCER_VAL, ID_FIXED_BIT});
  endtask : t_idcode

  // Listed and unlisted bypass codes alike
  task automatic t_bypass();
    logic [2:0] codes [5] = '{3'h1, 3'h2, 3'h3, 3'h5, OP_BYPASS};
    foreach (codes[i]) begin
      load(codes[i]);
      i_ctl.scan(1'b0, 8, 98'hB5, got);
      chk("bypass", got, 98'h6A);
    end
  endtask : t_bypass

  task automatic t_sample();
    @(posedge mclk);
    pin_in <= {49{2'h1}};
    core_out <= {49{2'h2}};
    repeat (4) @(posedge mclk);
    load(OP_SAMPLE);
    i_ctl.scan(1'b0, 98, {14{7'h4B}}, got);
    chk("sample", got, {49{2'h1}});
    // Pins are read between core edges, where they are settled
    repeat (8) @(negedge mclk);
    chk("core_path", pin_out, {49{2'h2}});
  endtask : t_sample

  task automatic t_extest();
    @(posedge mclk);
    pin_in <= {14{7'h4B}};
    repeat (4) @(posedge mclk);
    load(OP_EXTEST);
    i_ctl.scan(1'b0, 98, {7{14'h2C39}}, got);
    chk("extest_in", got, {14{7'h4B}});
    repeat (8) @(negedge mclk);
    chk("extest_out", pin_out, {7{14'h2C39}});
    load(OP_BYPASS);
    repeat (8) @(negedge mclk);
    chk("release", pin_out, {49{2'h2}});
  endtask : t_extest

  // Main sequence
  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    core_out = '0;
    pin_in = '0;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    i_ctl.tap_reset();
    t_idcode();
    t_bypass();
    t_sample();
    t_extest();
    final_report();
  end

  // Cuts a hang short
  initial begin
    repeat (100000) @(posedge mclk);
    mismatches++;
    final_report();
  end
endmodule : tb_top
